// [logic/pwm_shared_period_cfg.svh]
`ifndef PWM_SHARED_PERIOD_CFG_SVH
`define PWM_SHARED_PERIOD_CFG_SVH

// register offsets on the special-function bus
`define ADDR_INT_ENABLE_ONE   8'ha9
`define ADDR_INT_PRIORITY_ONE 8'hb9
`define ADDR_CLK_INV_CFG      8'hd1
`define ADDR_ENABLE_FLAG_CTL  8'hd2
`define ADDR_PERIOD_HIGH      8'hd3
`define ADDR_DUTY_LOW_A       8'hd4
`define ADDR_DUTY_HIGH_0      8'hd5
`define ADDR_DUTY_HIGH_1      8'hd6
`define ADDR_DUTY_HIGH_2      8'hd7
`define ADDR_DUTY_LOW_B       8'hdc
`define ADDR_DUTY_HIGH_3      8'hdd
`define ADDR_DUTY_HIGH_4      8'hde
`define ADDR_DUTY_HIGH_5      8'hdf

// field positions
`define BIT_OVF_IRQ_EN        1
`define BIT_OVF_IRQ_PRIO      1
`define BIT_MASTER_EN         7
`define BIT_OVF_FLAG          6
`define BIT_MODE_SEL          7
`define MSB_CLK_SEL           7
`define LSB_CLK_SEL           6
`define MSB_PERIOD_LOW        7
`define LSB_PERIOD_LOW        6

// implemented bits of the interrupt registers, upper bits read zero
`define INT_REG_MASK          8'h1f
// low duty field of register b has bit 6 unused
`define DUTY_LOW_B_MASK       8'hbf

// reset values
`define RST_REG8              8'h00
`define RST_CNT10             10'h000
`define RST_PRESCALE          5'h00

// prescaler terminal counts
`define PRESC_TC_DIV2         5'h01
`define PRESC_TC_DIV8         5'h07
`define PRESC_TC_DIV32        5'h1f

`endif

// [logic/pwm_shared_period_pkg.sv]
package pwm_shared_period_pkg;

    typedef enum logic [1:0] {
        CLK_DIV1  = 2'h0,
        CLK_DIV2  = 2'h1,
        CLK_DIV8  = 2'h2,
        CLK_DIV32 = 2'h3
    } clk_sel_t;

    typedef logic [9:0] count10_t;

endpackage : pwm_shared_period_pkg

// [logic/pwm_shared_period_control.sv]
// Summary of operation
// - clock select: undivided, /2, /8, /32
// - invert bit flips each channel output
// - counter increments, wraps after reaching period
// - shared period equals value plus one
// - period from high register plus low bits
// - master enable runs; clear stops, zeroes counter
// - disable keeps pins; channel enable releases
// - overflow sets the interrupt flag
// - one flag, one vector for all
// - channel enable routes waveform to pin
// - enable bit one gates overflow interrupt
// - priority bit selects low or high
// - non-inverted high width equals duty value in prescaled counter ticks
`timescale 1ns/1ps
`default_nettype none
`include "pwm_shared_period_cfg.svh"

module pwm_shared_period_control
    import pwm_shared_period_pkg::*;
#(
    parameter int NUM_CH = 6
) (
    input  wire logic              core_clk_i,  // system clock, 125 MHz
    input  wire logic              sys_rst_i,   // async reset, active high
    input  wire logic [7:0]        addr_i,      // register address
    input  wire logic [7:0]        wdata_i,     // write data
    input  wire logic              wr_i,        // write strobe
    input  wire logic              rd_i,        // read strobe
    output logic      [7:0]        rdata_o,     // read data, cycle after strobe
    output logic      [NUM_CH-1:0] pwm_o,       // channel pin levels
    output logic      [NUM_CH-1:0] pwm_oe_o,    // channel pin drive enables
    output logic                   irq_o,       // overflow interrupt request
    output logic                   irq_prio_o   // overflow interrupt priority
);

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0]  int_enable_one_q;
    logic [7:0]  int_priority_one_q;
    logic [7:0]  clk_inv_cfg_q;
    logic [7:0]  enable_ctl_q;       // bit 6 stored but never read back, see flag
    logic        overflow_flag_q;
    logic [7:0]  period_high_q;
    logic [7:0]  duty_low_a_q;
    logic [7:0]  duty_low_b_q;
    logic [7:0]  duty_high_q [NUM_CH];
    count10_t    period_act_q;
    count10_t    duty_act_q [NUM_CH];
    logic [7:0]  rdata_q;

    wire logic hit_ie    = (addr_i == `ADDR_INT_ENABLE_ONE);
    wire logic hit_ip    = (addr_i == `ADDR_INT_PRIORITY_ONE);
    wire logic hit_cfg   = (addr_i == `ADDR_CLK_INV_CFG);
    wire logic hit_con   = (addr_i == `ADDR_ENABLE_FLAG_CTL);
    wire logic hit_prd   = (addr_i == `ADDR_PERIOD_HIGH);
    wire logic hit_dla   = (addr_i == `ADDR_DUTY_LOW_A);
    wire logic hit_dlb   = (addr_i == `ADDR_DUTY_LOW_B);

    logic [NUM_CH-1:0] hit_dh;
    assign hit_dh[0] = (addr_i == `ADDR_DUTY_HIGH_0);
    assign hit_dh[1] = (addr_i == `ADDR_DUTY_HIGH_1);
    assign hit_dh[2] = (addr_i == `ADDR_DUTY_HIGH_2);
    assign hit_dh[3] = (addr_i == `ADDR_DUTY_HIGH_3);
    assign hit_dh[4] = (addr_i == `ADDR_DUTY_HIGH_4);
    assign hit_dh[5] = (addr_i == `ADDR_DUTY_HIGH_5);

    // flag as seen on the control register
    wire logic [7:0] con_view = {enable_ctl_q[7], overflow_flag_q, enable_ctl_q[5:0]};

    logic [7:0] dh_view;
    always_comb begin
        dh_view = `RST_REG8;
        for (int i = 0; i < NUM_CH; i++) begin
            if (hit_dh[i]) begin
                dh_view = duty_high_q[i];
            end
        end
    end

    // unmapped addresses read as zero
    wire logic [7:0] rd_mux =
        hit_ie  ? (int_enable_one_q & `INT_REG_MASK)   :
        hit_ip  ? (int_priority_one_q & `INT_REG_MASK) :
        hit_cfg ? clk_inv_cfg_q :
        hit_con ? con_view :
        hit_prd ? period_high_q :
        hit_dla ? duty_low_a_q :
        hit_dlb ? (duty_low_b_q & `DUTY_LOW_B_MASK) :
        dh_view;

    wire logic wr_ie  = wr_i & hit_ie;
    wire logic wr_ip  = wr_i & hit_ip;
    wire logic wr_cfg = wr_i & hit_cfg;
    wire logic wr_con = wr_i & hit_con;
    wire logic wr_prd = wr_i & hit_prd;
    wire logic wr_dla = wr_i & hit_dla;
    wire logic wr_dlb = wr_i & hit_dlb;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            int_enable_one_q   <= `RST_REG8;
            int_priority_one_q <= `RST_REG8;
            clk_inv_cfg_q      <= `RST_REG8;
            enable_ctl_q       <= `RST_REG8;
            period_high_q      <= `RST_REG8;
            duty_low_a_q       <= `RST_REG8;
            duty_low_b_q       <= `RST_REG8;
        end else begin
            if (wr_ie) int_enable_one_q <= wdata_i & `INT_REG_MASK;
            if (wr_ip) int_priority_one_q <= wdata_i & `INT_REG_MASK;
            if (wr_cfg) clk_inv_cfg_q <= wdata_i;
            if (wr_con) enable_ctl_q <= wdata_i;
            if (wr_prd) period_high_q <= wdata_i;
            if (wr_dla) duty_low_a_q <= wdata_i;
            if (wr_dlb) duty_low_b_q <= wdata_i & `DUTY_LOW_B_MASK;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= `RST_REG8;
        end else begin
            rdata_q <= rd_i ? rd_mux : `RST_REG8;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shadow loads: high byte write commits the whole 10-bit value,
    // so a low-bits-then-high order never exposes a half-written value

    // low bits of the period are taken at the high-byte write
    wire count10_t period_new = {wdata_i, duty_low_a_q[`MSB_PERIOD_LOW:`LSB_PERIOD_LOW]};

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            period_act_q <= `RST_CNT10;
        end else if (wr_prd) begin
            period_act_q <= period_new;
        end
    end

    // low duty bits: channels 0..2 in register a, 3..5 in register b
    logic [1:0] duty_low [NUM_CH];
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_duty
            if (c < 3) begin : g_a
                assign duty_low[c] = duty_low_a_q[2*c+1:2*c];
            end else begin : g_b
                assign duty_low[c] = duty_low_b_q[2*(c-3)+1:2*(c-3)];
            end

            always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    duty_high_q[c] <= `RST_REG8;
                    duty_act_q[c]  <= `RST_CNT10;
                end else if (wr_i && hit_dh[c]) begin
                    duty_high_q[c] <= wdata_i;
                    duty_act_q[c]  <= {wdata_i, duty_low[c]};
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // prescaler and shared counter

    wire logic     master_en = enable_ctl_q[`BIT_MASTER_EN];
    wire clk_sel_t clk_sel   = clk_sel_t'(clk_inv_cfg_q[`MSB_CLK_SEL:`LSB_CLK_SEL]);

    logic [4:0] presc_q;
    count10_t   count_q;

    // free-running divider; /2, /8 and /32 tick on their own terminal count, undivided ticks every cycle
    wire logic tick =
        (clk_sel == CLK_DIV1)  ? 1'b1 :
        (clk_sel == CLK_DIV2)  ? (presc_q[0] == `PRESC_TC_DIV2) :
        (clk_sel == CLK_DIV8)  ? (presc_q[2:0] == `PRESC_TC_DIV8) :
        (presc_q == `PRESC_TC_DIV32);

    // counter at or past period wraps; covers a period shrunk under it
    wire logic at_top   = (count_q >= period_act_q);
    wire logic overflow = master_en & tick & at_top;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            presc_q <= `RST_PRESCALE;
            count_q <= `RST_CNT10;
        end else if (!master_en) begin
            presc_q <= `RST_PRESCALE;
            count_q <= `RST_CNT10;
        end else begin
            presc_q <= presc_q + 5'h01;
            if (tick) begin
                count_q <= at_top ? `RST_CNT10 : count_q + 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overflow flag and interrupt

    wire logic flag_clr = wr_con & wdata_i[`BIT_OVF_FLAG];

    // a new overflow wins over a same-cycle write-one clear
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            overflow_flag_q <= 1'b0;
        end else if (overflow) begin
            overflow_flag_q <= 1'b1;
        end else if (flag_clr) begin
            overflow_flag_q <= 1'b0;
        end
    end

    wire logic irq_d = overflow_flag_q & int_enable_one_q[`BIT_OVF_IRQ_EN];

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o      <= 1'b0;
            irq_prio_o <= 1'b0;
        end else begin
            irq_o      <= irq_d;
            irq_prio_o <= int_priority_one_q[`BIT_OVF_IRQ_PRIO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel outputs

    logic [NUM_CH-1:0] wave;
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_wave
            // idle unit holds the non-inverted level low
            assign wave[c] = master_en & (count_q < duty_act_q[c]);
        end
    endgenerate

    wire logic [NUM_CH-1:0] inv_bits = clk_inv_cfg_q[NUM_CH-1:0];
    wire logic [NUM_CH-1:0] pin_en   = enable_ctl_q[NUM_CH-1:0];

    // master disable leaves pin enables alone; only channel bits release pins
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwm_o    <= '0;
            pwm_oe_o <= '0;
        end else begin
            pwm_o    <= wave ^ inv_bits;
            pwm_oe_o <= pin_en;
        end
    end

    assign rdata_o = rdata_q;

endmodule : pwm_shared_period_control
`default_nettype wire

// [tb/pwm_shared_period_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pwm_shared_period_cfg.svh"
module pwm_shared_period_checker #(
    parameter int NUM_CH = 6
) (
    input wire logic              core_clk_i, // clock
    input wire logic              sys_rst_i,  // reset
    input wire logic [7:0]        addr_i,     // address
    input wire logic [7:0]        wdata_i,    // write data
    input wire logic              wr_i,       // write strobe
    input wire logic              rd_i,       // read strobe
    input wire logic [7:0]        rdata_o,    // read data
    input wire logic [NUM_CH-1:0] pwm_o,      // levels
    input wire logic [NUM_CH-1:0] pwm_oe_o,   // enables
    input wire logic              irq_o,      // request
    input wire logic              irq_prio_o  // priority
);
    logic [7:0] cfg_q;
    logic       mst_q;
    logic       ien_q;
    // shadows rebuilt from bus writes only
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_q <= 8'h00;
            mst_q <= 1'b0;
            ien_q <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == `ADDR_CLK_INV_CFG) cfg_q <= wdata_i;
            if (addr_i == `ADDR_ENABLE_FLAG_CTL) mst_q <= wdata_i[7];
            if (addr_i == `ADDR_INT_ENABLE_ONE) ien_q <= wdata_i[1];
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // no writes, so the shadows cannot move under the check
    sequence s_idle3;
        (!mst_q && !wr_i) [*3];
    endsequence
    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero");
    AST_UNMAPPED: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_CFG_READ: assert property (rd_i && addr_i == `ADDR_CLK_INV_CFG |=> rdata_o == cfg_q)
        else $error("config readback wrong");
    AST_IE_UPPER: assert property (rd_i && addr_i == `ADDR_INT_ENABLE_ONE |=> rdata_o[7:5] == 3'h0)
        else $error("enable upper bits set");
    AST_PIN_EN: assert property (wr_i && addr_i == `ADDR_ENABLE_FLAG_CTL
        |=> ##1 pwm_oe_o == $past(wdata_i[NUM_CH-1:0], 2))
        else $error("pin enables wrong");
    AST_PRIO: assert property (wr_i && addr_i == `ADDR_INT_PRIORITY_ONE
        |=> ##1 irq_prio_o == $past(wdata_i[1], 2))
        else $error("priority wrong");
    AST_IRQ_MASK: assert property (!ien_q |=> !irq_o)
        else $error("masked request seen");
    AST_IDLE_PINS: assert property (s_idle3 |=> pwm_o == cfg_q[NUM_CH-1:0])
        else $error("stopped outputs wrong");
endmodule : pwm_shared_period_checker
bind pwm_shared_period_control pwm_shared_period_checker #(.NUM_CH(NUM_CH)) u_chk (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o),
    .irq_o(irq_o), .irq_prio_o(irq_prio_o));
`default_nettype wire

// [tb/pwm_pin_load.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_pin_load #(
    parameter int NUM_CH = 6
) (
    input  wire logic [NUM_CH-1:0] pwm_i, // channel levels
    input  wire logic [NUM_CH-1:0] oe_i,  // drive enables
    output logic      [NUM_CH-1:0] pin_o  // pad level
);
    // released pads sit on the board pull-down
    assign pin_o = pwm_i & oe_i;
endmodule : pwm_pin_load
`default_nettype wire

// [tb/pwm_shared_period_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_shared_period_control_tb;
    typedef struct packed {logic [1:0] sel; logic [9:0] prd, dty; logic inv;} row_t;
    logic       clk, rst, wr, rd, irq, prio;
    logic [7:0] addr, wdat, rdat, v;
    logic [5:0] pwm, oe, pin;
    int         error_cnt = 0, checked = 0, cyc = 0, hi, per, dv;
    row_t       r;
    row_t       rows [5] = '{'{2'h0, 10'h005, 10'h002, 1'b0}, '{2'h1, 10'h003, 10'h001, 1'b0},
        '{2'h2, 10'h002, 10'h001, 1'b0}, '{2'h3, 10'h001, 10'h001, 1'b0},
        '{2'h0, 10'h205, 10'h103, 1'b1}};
    pwm_shared_period_control u_pwm_shared_period_control (.core_clk_i(clk), .sys_rst_i(rst),
        .addr_i(addr), .wdata_i(wdat), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .pwm_o(pwm),
        .pwm_oe_o(oe), .irq_o(irq), .irq_prio_o(prio));
    pwm_pin_load u_pwm_pin_load (.pwm_i(pwm), .oe_i(oe), .pin_o(pin));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrt
    task automatic rdb(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdat;
    endtask : rdb
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // bounded so a stuck pin ends in a mismatch, not a hang
    task automatic meas(output int h, output int p);
        int n;
        n = 0;
        h = 0;
        for (; pin[0] !== 1'b0 && n < 2000; n++) @(negedge clk);
        for (; pin[0] !== 1'b1 && n < 4000; n++) @(negedge clk);
        for (; pin[0] === 1'b1 && h < 2000; h++) @(negedge clk);
        for (p = h; pin[0] === 1'b0 && p < 4000; p++) @(negedge clk);
    endtask : meas
    task automatic complete_run();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdat = 8'h00;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1 chk({irq, prio, pwm, oe}, 16'h0000);
        foreach (rows[i]) begin
            r = rows[i];
            dv = (r.sel == 2'h0) ? 1 : (r.sel == 2'h1) ? 2 : (r.sel == 2'h2) ? 8 : 32;
            wrt(8'hd1, {r.sel, 5'h00, r.inv});
            wrt(8'hd4, {r.prd[1:0], 4'h0, r.dty[1:0]});
            wrt(8'hd3, r.prd[9:2]);
            wrt(8'hd5, r.dty[9:2]);
            wrt(8'hd2, 8'h81);
            meas(hi, per);
            chk(16'(per), 16'((r.prd + 1) * dv));
            chk(16'(hi), 16'(r.inv ? (r.prd + 1 - r.dty) * dv : r.dty * dv));
            $display("row %0d done", i);
        end
        wrt(8'ha9, 8'h02);
        for (int n = 0; n < 600 && irq !== 1'b1; n++) @(posedge clk);
        chk(irq, 1'b1);
        wrt(8'ha9, 8'h00);
        @(posedge clk);
        #1 chk(irq, 1'b0);
        wrt(8'ha9, 8'hff);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        rdb(8'ha9);
        chk(v, 16'h001f);
        wrt(8'hb9, 8'hff);
        @(posedge clk);
        #1 chk(prio, 1'b1);
        rdb(8'hb9);
        chk(v, 16'h001f);
        wrt(8'hd2, 8'h41);
        // a last overflow may win over the first clear; repeat it stopped
        wrt(8'hd2, 8'h41);
        repeat (4) @(posedge clk);
        #1 chk({irq, oe, pin}, 16'h0041);
        rdb(8'hd2);
        chk(v, 16'h0001);
        rdb(8'hd1);
        chk(v, 16'h0001);
        wrt(8'h00, 8'hff);
        rdb(8'h00);
        chk(v, 16'h0000);
        wrt(8'hd2, 8'h00);
        @(posedge clk);
        #1 chk({oe, pin}, 16'h0000);
        $display("irq and pin tests done");
        complete_run();
    end
endmodule : pwm_shared_period_control_tb
`default_nettype wire
